// *** design/msc_defines.svh ***
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH
// Summary of operation
// - Port2 ctrl bits 7..4 enable push-pull on pins 2.5..2.2; reset 0.
// - Bits 3:2, 1:0 hold pin 2.1, 2.0 modes; reset 01; 11 undefined.
// - Option bit 7 sets one-wire serial mode on pin 3.1; reset 0.
// - Option bit 6 enables touch-key clock auto adjust; reset 0.
// - Option bits 5:4 pick watchdog period 480/240/120/60 ms; reset 00.
// - Option bits 3:2 pick ADC clock sysclk /32 /16 /8 /4; reset 00.
// - Option bits 1:0 pick tick period 32768/16384/8192/128 cycles.
// - Flag bit 7 is read-only low-supply indication.
// - Flag bit 5 sets on touch done; DFh write or touch start clears.
// - Flag bit 4 sets on ADC done; EFh write or ADC start clears.
// - Flag bit 1 sets on wake-enabled port1 pin change; irq enable ignored.
// - Port1 change flag clears on service entry or FDh write.
// - Flag bit 0 sets on tick expiry; service entry or FEh clears.
// - Port1 wake enable register, bit n for pin n; reset 00h.
// - Writing 56h to the command register issues a software reset.
// - Writing 65h sets the self-program permit; other values clear it.
// - Command reads give permit in bit 0, watchdog timeout in bit 1.
// - Self-program area combines the permit with the flash area lock.

// Register indices; byte address is four times the index
`define MSC_IDX_PORT2_CTRL 10'h093
`define MSC_IDX_OPTION 10'h094
`define MSC_IDX_FLAGS 10'h095
`define MSC_IDX_WAKE 10'h096
`define MSC_IDX_COMMAND 10'h097

// Reset values
`define MSC_RST_PORT2_CTRL 8'h05
`define MSC_RST_OPTION 8'h00
`define MSC_RST_WAKE 8'h00

// Field positions
`define MSC_PUSHPULL_HI 7
`define MSC_PUSHPULL_LO 4
`define MSC_PIN21_HI 3
`define MSC_PIN21_LO 2
`define MSC_PIN20_HI 1
`define MSC_PIN20_LO 0
`define MSC_ONE_WIRE_BIT 7
`define MSC_TOUCH_ADJ_BIT 6
`define MSC_WDT_HI 5
`define MSC_WDT_LO 4
`define MSC_ADC_HI 3
`define MSC_ADC_LO 2
`define MSC_TICK_HI 1
`define MSC_TICK_LO 0
`define MSC_LOW_SUPPLY_BIT 7
`define MSC_TOUCH_BIT 5
`define MSC_ADC_BIT 4
`define MSC_PORT1_BIT 1
`define MSC_TICK_BIT 0
`define MSC_PERMIT_BIT 0
`define MSC_WDT_TO_BIT 1

// Command codes
`define MSC_CMD_SOFT_RESET 8'h56
`define MSC_CMD_PERMIT 8'h65

// Decoded period and divider values
`define MSC_WDT_MS_00 9'd480
`define MSC_WDT_MS_01 9'd240
`define MSC_WDT_MS_10 9'd120
`define MSC_WDT_MS_11 9'd60
`define MSC_ADC_DIV_00 6'd32
`define MSC_ADC_DIV_01 6'd16
`define MSC_ADC_DIV_10 6'd8
`define MSC_ADC_DIV_11 6'd4
`define MSC_TICK_00 16'd32768
`define MSC_TICK_01 16'd16384
`define MSC_TICK_10 16'd8192
`define MSC_TICK_11 16'd128
`endif

// *** design/msc_pkg.sv ***
package msc_pkg;
  typedef logic [7:0] msc_byte_t;
  typedef logic [1:0] msc_sel_t;
  typedef logic [9:0] msc_index_t;
endpackage : msc_pkg

// *** design/msc_event_flag.sv ***
`timescale 1ns/1ps
// Sticky event flag; a set in the same cycle as a clear wins
module msc_event_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);
  ////////////////////////////////////////////////////////////////////////
  // Set has priority so no event is lost during a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end
endmodule : msc_event_flag

// *** design/msc_option_decode.sv ***
`timescale 1ns/1ps
`include "msc_defines.svh"
// Turns option select codes into the figures the peripherals use
module msc_option_decode
  import msc_pkg::*;
(
  input wire msc_sel_t wdt_sel,
  input wire msc_sel_t adc_sel,
  input wire msc_sel_t tick_sel,
  output logic [8:0] wdt_ms,
  output logic [5:0] adc_div,
  output logic [15:0] tick_cycles
);
  ////////////////////////////////////////////////////////////////////////
  // Watchdog period, halved per step
  always_comb begin
    case (wdt_sel)
      2'b00: wdt_ms = `MSC_WDT_MS_00;
      2'b01: wdt_ms = `MSC_WDT_MS_01;
      2'b10: wdt_ms = `MSC_WDT_MS_10;
      default: wdt_ms = `MSC_WDT_MS_11;
    endcase
  end

  // ADC clock divider from system clock
  always_comb begin
    case (adc_sel)
      2'b00: adc_div = `MSC_ADC_DIV_00;
      2'b01: adc_div = `MSC_ADC_DIV_01;
      2'b10: adc_div = `MSC_ADC_DIV_10;
      default: adc_div = `MSC_ADC_DIV_11;
    endcase
  end

  // Tick period; last code jumps to a short period, not a halving
  always_comb begin
    case (tick_sel)
      2'b00: tick_cycles = `MSC_TICK_00;
      2'b01: tick_cycles = `MSC_TICK_01;
      2'b10: tick_cycles = `MSC_TICK_10;
      default: tick_cycles = `MSC_TICK_11;
    endcase
  end
endmodule : msc_option_decode

// *** design/msc_sys_ctrl.sv ***
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "msc_defines.svh"
// Miscellaneous system control registers behind an APB slave
module msc_sys_ctrl
  import msc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pin25_pushpull_en,
  output logic pin24_pushpull_en,
  output logic pin23_pushpull_en,
  output logic pin22_pushpull_en,
  output msc_sel_t pin21_mode_sel,
  output msc_sel_t pin20_mode_sel,
  output logic serial_one_wire_en,
  output logic touch_clk_auto_adjust,
  output msc_sel_t watchdog_period_sel,
  output msc_sel_t adc_clk_div_sel,
  output msc_sel_t tick_timer_period_sel,
  output logic [8:0] watchdog_period_ms,
  output logic [5:0] adc_clk_div,
  output logic [15:0] tick_timer_period,
  input wire logic low_supply_detect,
  input wire logic touch_conv_done,
  input wire logic touch_start_bit,
  input wire logic adc_conv_done,
  input wire logic adc_start_bit,
  input wire logic [7:0] port1_pins,
  input wire logic port1_isr_entry,
  input wire logic tick_timer_expired,
  input wire logic tick_isr_entry,
  input wire logic watchdog_timeout,
  input wire logic [1:0] flash_area_lock,
  output msc_byte_t port1_wake_en,
  output logic low_supply_flag,
  output logic touch_done_flag,
  output logic adc_done_flag,
  output logic port1_change_flag,
  output logic tick_timer_flag,
  output logic soft_reset_cmd,
  output logic flash_selfprog_permit,
  output logic [2:0] flash_selfprog_area
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode helper

  // Word aligned hit on a register index
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input msc_index_t idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : reg_hit

  // Any of the five registers
  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = reg_hit(addr, `MSC_IDX_PORT2_CTRL) ||
                 reg_hit(addr, `MSC_IDX_OPTION) ||
                 reg_hit(addr, `MSC_IDX_FLAGS) ||
                 reg_hit(addr, `MSC_IDX_WAKE) ||
                 reg_hit(addr, `MSC_IDX_COMMAND);
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////
  // Bus phase tracking

  logic setup_phase;
  logic access_done;
  logic wr_ok;
  logic wr_port2;
  logic wr_option;
  logic wr_flags;
  logic wr_wake;
  logic wr_command;
  msc_byte_t wbyte;

  // Setup cycle of a new transfer
  assign setup_phase = psel && !penable;
  // Completing edge: the one edge where writes land
  assign access_done = psel && penable && pready;
  // Unmapped writes are dropped and flagged with an error
  assign wr_ok = access_done && pwrite && !pslverr;
  assign wbyte = pwdata[7:0];

  // Per register write strobes
  assign wr_port2 = wr_ok && reg_hit(paddr, `MSC_IDX_PORT2_CTRL);
  assign wr_option = wr_ok && reg_hit(paddr, `MSC_IDX_OPTION);
  assign wr_flags = wr_ok && reg_hit(paddr, `MSC_IDX_FLAGS);
  assign wr_wake = wr_ok && reg_hit(paddr, `MSC_IDX_WAKE);
  assign wr_command = wr_ok && reg_hit(paddr, `MSC_IDX_COMMAND);

  ////////////////////////////////////////////////////////////////////////
  // Stored control registers

  msc_byte_t port2_drive_mode_ctrl;
  msc_byte_t system_option;

  // Port2 drive and pin mode; undefined mode code is stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_drive_mode_ctrl <= `MSC_RST_PORT2_CTRL;
    end else if (wr_port2) begin
      port2_drive_mode_ctrl <= wbyte;
    end
  end

  // Option register steering several peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_option <= `MSC_RST_OPTION;
    end else if (wr_option) begin
      system_option <= wbyte;
    end
  end

  // Port1 wake enables, one bit per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_wake_en <= `MSC_RST_WAKE;
    end else if (wr_wake) begin
      port1_wake_en <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field outputs, each a copy of its stored bits

  // Split into per pin ports so the pad logic sees plain flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin25_pushpull_en <= 1'b0;
      pin24_pushpull_en <= 1'b0;
      pin23_pushpull_en <= 1'b0;
      pin22_pushpull_en <= 1'b0;
      pin21_mode_sel <= 2'b01;
      pin20_mode_sel <= 2'b01;
    end else begin
      {pin25_pushpull_en, pin24_pushpull_en,
       pin23_pushpull_en, pin22_pushpull_en} <=
        port2_drive_mode_ctrl[`MSC_PUSHPULL_HI:`MSC_PUSHPULL_LO];
      pin21_mode_sel <=
        port2_drive_mode_ctrl[`MSC_PIN21_HI:`MSC_PIN21_LO];
      pin20_mode_sel <=
        port2_drive_mode_ctrl[`MSC_PIN20_HI:`MSC_PIN20_LO];
    end
  end

  // Option fields out to their peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_one_wire_en <= 1'b0;
      touch_clk_auto_adjust <= 1'b0;
      watchdog_period_sel <= 2'b00;
      adc_clk_div_sel <= 2'b00;
      tick_timer_period_sel <= 2'b00;
    end else begin
      serial_one_wire_en <= system_option[`MSC_ONE_WIRE_BIT];
      touch_clk_auto_adjust <= system_option[`MSC_TOUCH_ADJ_BIT];
      watchdog_period_sel <= system_option[`MSC_WDT_HI:`MSC_WDT_LO];
      adc_clk_div_sel <= system_option[`MSC_ADC_HI:`MSC_ADC_LO];
      tick_timer_period_sel <=
        system_option[`MSC_TICK_HI:`MSC_TICK_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded figures for the peripherals

  logic [8:0] next_wdt_ms;
  logic [5:0] next_adc_div;
  logic [15:0] next_tick;

  msc_option_decode u_decode (
    .wdt_sel(system_option[`MSC_WDT_HI:`MSC_WDT_LO]),
    .adc_sel(system_option[`MSC_ADC_HI:`MSC_ADC_LO]),
    .tick_sel(system_option[`MSC_TICK_HI:`MSC_TICK_LO]),
    .wdt_ms(next_wdt_ms),
    .adc_div(next_adc_div),
    .tick_cycles(next_tick)
  );

  // Registered so the figures change cleanly, in the same cycle as the fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_period_ms <= `MSC_WDT_MS_00;
      adc_clk_div <= `MSC_ADC_DIV_00;
      tick_timer_period <= `MSC_TICK_00;
    end else begin
      watchdog_period_ms <= next_wdt_ms;
      adc_clk_div <= next_adc_div;
      tick_timer_period <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port1 change detection

  msc_byte_t p1_prev;
  logic p1_armed;
  logic p1_change;

  // First sample after reset only primes the history, no false change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_prev <= 8'h00;
      p1_armed <= 1'b0;
    end else begin
      p1_prev <= port1_pins;
      p1_armed <= 1'b1;
    end
  end

  // The port1 irq enable is deliberately not part of this term
  assign p1_change = p1_armed &&
                     (|((port1_pins ^ p1_prev) & port1_wake_en));

  ////////////////////////////////////////////////////////////////////////
  // Shared interrupt flags

  logic clr_touch;
  logic clr_adc;
  logic clr_port1;
  logic clr_tick;

  // A written zero clears; a written one leaves the flag alone
  assign clr_touch = (wr_flags && !wbyte[`MSC_TOUCH_BIT]) ||
                     touch_start_bit;
  assign clr_adc = (wr_flags && !wbyte[`MSC_ADC_BIT]) ||
                   adc_start_bit;
  assign clr_port1 = (wr_flags && !wbyte[`MSC_PORT1_BIT]) ||
                     port1_isr_entry;
  assign clr_tick = (wr_flags && !wbyte[`MSC_TICK_BIT]) ||
                    tick_isr_entry;

  // Touch done is already qualified by sysclk speed in the touch block
  msc_event_flag u_touch_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(touch_conv_done),
    .clr_evt(clr_touch),
    .flag(touch_done_flag)
  );

  msc_event_flag u_adc_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(adc_conv_done),
    .clr_evt(clr_adc),
    .flag(adc_done_flag)
  );

  msc_event_flag u_port1_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(p1_change),
    .clr_evt(clr_port1),
    .flag(port1_change_flag)
  );

  msc_event_flag u_tick_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(tick_timer_expired),
    .clr_evt(clr_tick),
    .flag(tick_timer_flag)
  );

  // Low supply follows the detector; no bus path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_supply_flag <= 1'b0;
    end else begin
      low_supply_flag <= low_supply_detect;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decoder

  logic wdt_to_flag;

  // Codes act only on the completing edge; nothing is stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_cmd <= 1'b0;
    end else begin
      soft_reset_cmd <= wr_command &&
                        (wbyte == `MSC_CMD_SOFT_RESET);
    end
  end

  // Any code but the arming one drops the permit; this is how
  // software closes the window after each programming access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_selfprog_permit <= 1'b0;
    end else if (wr_command) begin
      flash_selfprog_permit <= (wbyte == `MSC_CMD_PERMIT);
    end
  end

  // Area is the lock setting gated by the permit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_selfprog_area <= 3'b000;
    end else if (wr_command) begin
      flash_selfprog_area <= (wbyte == `MSC_CMD_PERMIT) ?
                             {1'b1, flash_area_lock} : 3'b000;
    end else if (flash_selfprog_permit) begin
      flash_selfprog_area <= {1'b1, flash_area_lock};
    end
  end

  // Watchdog timeout status as seen by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_to_flag <= 1'b0;
    end else begin
      wdt_to_flag <= watchdog_timeout;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  msc_byte_t next_rdata;

  // Unused and reserved bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_hit(paddr, `MSC_IDX_PORT2_CTRL)) begin
      next_rdata = port2_drive_mode_ctrl;
    end else if (reg_hit(paddr, `MSC_IDX_OPTION)) begin
      next_rdata = system_option;
    end else if (reg_hit(paddr, `MSC_IDX_FLAGS)) begin
      next_rdata[`MSC_LOW_SUPPLY_BIT] = low_supply_flag;
      next_rdata[`MSC_TOUCH_BIT] = touch_done_flag;
      next_rdata[`MSC_ADC_BIT] = adc_done_flag;
      next_rdata[`MSC_PORT1_BIT] = port1_change_flag;
      next_rdata[`MSC_TICK_BIT] = tick_timer_flag;
    end else if (reg_hit(paddr, `MSC_IDX_WAKE)) begin
      next_rdata = port1_wake_en;
    end else if (reg_hit(paddr, `MSC_IDX_COMMAND)) begin
      next_rdata[`MSC_PERMIT_BIT] = flash_selfprog_permit;
      next_rdata[`MSC_WDT_TO_BIT] = wdt_to_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer

  // Fixed one-cycle access phase: data is captured in setup, so a
  // flag that moves during the access shows on the next read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= !reg_mapped(paddr);
      prdata <= (pwrite || !reg_mapped(paddr)) ? 32'h0000_0000 :
                {24'h00_0000, next_rdata};
    end else if (access_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : msc_sys_ctrl

// *** verification/msc_sys_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "msc_defines.svh"
// Watches bus timing, command decode and flag behaviour at the top ports
module msc_sys_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic touch_conv_done,
  input wire logic touch_start_bit,
  input wire logic tick_timer_expired,
  input wire logic tick_isr_entry,
  input wire logic low_supply_detect,
  input wire logic low_supply_flag,
  input wire logic touch_done_flag,
  input wire logic tick_timer_flag,
  input wire logic soft_reset_cmd,
  input wire logic flash_selfprog_permit
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // Bus phases as plain wires, so $past only ever sees a signal
  logic setup_ph, xfer_done, addr_hit, cmd_wr, reset_req, arm_req, flag_wr;
  assign setup_ph = psel && !penable;
  assign xfer_done = psel && penable && pready;
  assign addr_hit = paddr[1:0] == 2'b00 && paddr[11:2] >= `MSC_IDX_PORT2_CTRL
    && paddr[11:2] <= `MSC_IDX_COMMAND;
  assign cmd_wr = xfer_done && pwrite && paddr[11:2] == `MSC_IDX_COMMAND;
  assign reset_req = cmd_wr && pwdata[7:0] == 8'h56;
  assign arm_req = cmd_wr && pwdata[7:0] == 8'h65;
  assign flag_wr = xfer_done && pwrite && paddr[11:2] == `MSC_IDX_FLAGS;
  ////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (setup_ph |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (setup_ph && !addr_hit |=>
    pslverr && prdata == 32'h0000_0000)
    else $error("no error on bad address");
  a_ok_mapped: assert property (setup_ph && addr_hit |=> !pslverr)
    else $error("error on mapped address");
  a_read_upper_zero: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h00_0000) else $error("read upper bits not zero");
  a_soft_reset_pulse: assert property (reset_req |=>
    soft_reset_cmd ##1 !soft_reset_cmd) else $error("soft reset pulse wrong");
  a_soft_reset_cause: assert property ($rose(soft_reset_cmd) |->
    $past(reset_req)) else $error("soft reset without command");
  a_permit_arm: assert property (arm_req |-> ##[1:2]
    flash_selfprog_permit) else $error("permit not set");
  a_permit_drop: assert property (cmd_wr && !arm_req |-> ##[1:2]
    !flash_selfprog_permit) else $error("permit not cleared");
  a_touch_set: assert property (touch_conv_done |=> touch_done_flag)
    else $error("touch flag not set");
  a_touch_start_clr: assert property (touch_start_bit && !touch_conv_done
    |=> !touch_done_flag) else $error("touch flag not cleared by start");
  a_flag_write_clr: assert property (flag_wr && !pwdata[5]
    && !touch_conv_done |=> !touch_done_flag)
    else $error("flag write ignored");
  a_tick_isr_clr: assert property (tick_isr_entry && !tick_timer_expired
    |=> !tick_timer_flag) else $error("tick flag not cleared on service");
  a_low_supply_copy: assert property (1'b1 |=>
    low_supply_flag == $past(low_supply_detect))
    else $error("low supply lag");
  // Main scenarios reached
  c_soft_reset: cover property (reset_req ##1 soft_reset_cmd);
  c_bad_address: cover property (setup_ph && !addr_hit);
  c_set_wins: cover property (touch_conv_done && touch_start_bit);
endmodule : msc_sys_ctrl_checker

bind msc_sys_ctrl msc_sys_ctrl_checker u_checker (.*);

// *** verification/msc_sys_ctrl_bench.sv ***
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_sys_ctrl_bench;
  import msc_pkg::*;
  localparam logic [11:0] A_P2 = {`MSC_IDX_PORT2_CTRL, 2'b00};
  localparam logic [11:0] A_OP = {`MSC_IDX_OPTION, 2'b00};
  localparam logic [11:0] A_FL = {`MSC_IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_WK = {`MSC_IDX_WAKE, 2'b00};
  localparam logic [11:0] A_CM = {`MSC_IDX_COMMAND, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pin25_pushpull_en, pin24_pushpull_en, pin23_pushpull_en;
  logic pin22_pushpull_en, serial_one_wire_en, touch_clk_auto_adjust, e;
  msc_sel_t pin21_mode_sel, pin20_mode_sel, watchdog_period_sel;
  msc_sel_t adc_clk_div_sel, tick_timer_period_sel;
  logic [8:0] watchdog_period_ms;
  logic [5:0] adc_clk_div;
  logic [15:0] tick_timer_period;
  logic low_supply_detect, touch_conv_done, touch_start_bit, adc_conv_done;
  logic adc_start_bit, port1_isr_entry, tick_timer_expired, tick_isr_entry;
  logic watchdog_timeout, low_supply_flag, touch_done_flag, adc_done_flag;
  logic port1_change_flag, tick_timer_flag, soft_reset_cmd;
  logic flash_selfprog_permit;
  logic [7:0] port1_pins;
  logic [1:0] flash_area_lock;
  logic [2:0] flash_selfprog_area;
  msc_byte_t port1_wake_en;
  int bad_count, checks, cycles;

  // Every port has a bench signal of the same name
  msc_sys_ctrl DUT (.*);

  ////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under a thousand cycles
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One transfer; idle cycle first so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask : wr

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks

  // Order: touch set, touch start, adc set, adc start, tick set/isr, port1 isr
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    {touch_conv_done, touch_start_bit, adc_conv_done, adc_start_bit,
     tick_timer_expired, tick_isr_entry, port1_isr_entry} <= m;
    @(posedge pclk);
    {touch_conv_done, touch_start_bit, adc_conv_done, adc_start_bit,
     tick_timer_expired, tick_isr_entry, port1_isr_entry} <= 7'h00;
    @(posedge pclk);
  endtask : pulse

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [11:0] ad [5] = '{A_P2, A_OP, A_FL, A_WK, A_CM};
    logic [7:0] rv [5] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 8'h00, r, e);
      chk(r, {24'h00_0000, rv[i]});
    end
    chk({watchdog_period_ms, adc_clk_div, tick_timer_period},
        {9'd480, 6'd32, 16'd32768});
  endtask : t_reset

  // Mode code 11 is stored as written
  task automatic t_port2;
    logic [7:0] v [2] = '{8'hA3, 8'h5E};
    for (int i = 0; i < 2; i++) begin
      wr(A_P2, v[i]);
      ticks(3);
      chk({pin25_pushpull_en, pin24_pushpull_en, pin23_pushpull_en,
           pin22_pushpull_en, pin21_mode_sel, pin20_mode_sel}, v[i]);
      apb(1'b0, A_P2, 8'h00, r, e);
      chk(r, {24'h00_0000, v[i]});
    end
  endtask : t_port2

  task automatic t_option;
    logic [8:0] ms [4] = '{9'd480, 9'd240, 9'd120, 9'd60};
    logic [5:0] dv [4] = '{6'd32, 6'd16, 6'd8, 6'd4};
    logic [15:0] tp [4] = '{16'd32768, 16'd16384, 16'd8192, 16'd128};
    logic [1:0] k;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      d = {k[1], k[0], k, k, k};
      wr(A_OP, d);
      ticks(4);
      chk({serial_one_wire_en, touch_clk_auto_adjust, watchdog_period_sel,
           adc_clk_div_sel, tick_timer_period_sel}, d);
      chk({watchdog_period_ms, adc_clk_div, tick_timer_period},
          {ms[i], dv[i], tp[i]});
      apb(1'b0, A_OP, 8'h00, r, e);
      chk(r, {24'h00_0000, d});
    end
  endtask : t_option

  task automatic t_flags;
    logic [7:0] wv [5] = '{8'hDF, 8'hEF, 8'hFD, 8'hFE, 8'h00};
    logic [7:0] xv [5] = '{8'h93, 8'h83, 8'h81, 8'h80, 8'h80};
    low_supply_detect <= 1'b1;
    wr(A_WK, 8'h01);
    apb(1'b0, A_WK, 8'h00, r, e);
    chk(r, 32'h0000_0001);
    chk(port1_wake_en, 32'h0000_0001);
    // A change on a pin whose wake bit is clear must not flag
    port1_pins <= 8'h02;
    ticks(2);
    chk(port1_change_flag, 32'h0);
    port1_pins <= 8'h03;
    ticks(2);
    chk(port1_change_flag, 32'h1);
    pulse(7'b1010100);
    apb(1'b0, A_FL, 8'h00, r, e);
    chk(r, 32'h0000_00B3);
    for (int i = 0; i < 5; i++) begin
      wr(A_FL, wv[i]);
      apb(1'b0, A_FL, 8'h00, r, e);
      chk(r, {24'h00_0000, xv[i]});
    end
    // Set and start in one cycle: the set wins
    pulse(7'b1100000);
    chk(touch_done_flag, 32'h1);
    pulse(7'b0100000);
    chk(touch_done_flag, 32'h0);
    pulse(7'b0010000);
    chk(adc_done_flag, 32'h1);
    pulse(7'b0001000);
    chk(adc_done_flag, 32'h0);
    pulse(7'b0000100);
    chk(tick_timer_flag, 32'h1);
    pulse(7'b0000010);
    chk(tick_timer_flag, 32'h0);
    port1_pins <= 8'h02;
    ticks(2);
    chk(port1_change_flag, 32'h1);
    pulse(7'b0000001);
    chk(port1_change_flag, 32'h0);
    low_supply_detect <= 1'b0;
    ticks(2);
    chk(low_supply_flag, 32'h0);
  endtask : t_flags

  // Arm, reset, re-arm, then drop the permit with an ordinary value
  task automatic t_command;
    logic [7:0] cv [4] = '{8'h65, 8'h56, 8'h65, 8'hAA};
    logic arm;
    watchdog_timeout <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      arm = cv[i] == 8'h65;
      wr(A_CM, cv[i]);
      ticks(1);
      chk(soft_reset_cmd, {31'h0, cv[i] == 8'h56});
      ticks(3);
      chk(flash_selfprog_permit, {31'h0, arm});
      chk(flash_selfprog_area, arm ? 32'h6 : 32'h0);
      apb(1'b0, A_CM, 8'h00, r, e);
      chk(r, {30'h0, 1'b1, arm});
    end
  endtask : t_command

  task automatic t_unmapped;
    apb(1'b1, 12'h260, 8'hFF, r, e);
    chk(e, 32'h1);
    apb(1'b0, A_P2 + 12'h001, 8'h00, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h093, 8'h00, r, e);
    chk(e, 32'h1);
  endtask : t_unmapped

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {low_supply_detect, touch_conv_done, touch_start_bit, adc_conv_done} = '0;
    {adc_start_bit, port1_isr_entry, tick_timer_expired, tick_isr_entry} = '0;
    watchdog_timeout = 1'b0;
    port1_pins = 8'h00;
    flash_area_lock = 2'b10;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port2();
    t_option();
    t_flags();
    t_command();
    t_unmapped();
    complete_run();
  end
endmodule : msc_sys_ctrl_bench
